/* logic/timer_ctl_pkg.sv */
// Constants and types for the timer buffer/update control block
package timer_ctl_pkg;
   localparam int IDX_W = 8;
   localparam int NUM_CMP = 3;
   typedef logic [IDX_W-1:0] idx_t;

   // Register indices; byte address is four times the index
   localparam idx_t IDX_CTRL     = 8'h00;
   localparam idx_t IDX_CFG      = 8'h01;
   localparam idx_t IDX_SPLIT    = 8'h03;
   localparam idx_t IDX_DLC_CLR  = 8'h04;
   localparam idx_t IDX_DLC_SET  = 8'h05;
   localparam idx_t IDX_BV_CLR   = 8'h06;
   localparam idx_t IDX_BV_SET   = 8'h07;
   localparam idx_t IDX_EVENT_INPUT_CONTROL   = 8'h09;
   localparam idx_t IDX_COUNT    = 8'h20;
   localparam idx_t IDX_PERIOD_BUFFER   = 8'h36;
   localparam idx_t IDX_CMPBUF0  = 8'h38;
   localparam idx_t IDX_CMP_STEP = 8'h02;

   // Field positions
   localparam int ENABLE_BIT = 0;
   localparam int SPLIT_BIT  = 0;
   localparam int AUTO_LOCK_UPDATE_BIT  = 3;
   localparam int CMPEN_LSB  = 4;
   localparam int DIR_BIT    = 0;
   localparam int LOCK_UPDATE_BIT   = 1;
   localparam int CMD_LSB    = 2;
   localparam int CMD_MSB    = 3;
   localparam int BV_MSB     = 3;
   localparam int EVA_EN_BIT = 0;
   localparam int EVA_LSB    = 1;
   localparam int EVB_EN_BIT = 4;
   localparam int EVB_LSB    = 5;

   // Reset values
   localparam logic [7:0]  RST8  = 8'h00;
   localparam logic [15:0] RST16 = 16'h0000;
   localparam logic [31:0] RST32 = 32'h0000_0000;

   typedef enum logic [1:0] {
      CMD_NONE    = 2'h0,
      CMD_UPDATE  = 2'h1,
      CMD_RESTART = 2'h2,
      CMD_HARD    = 2'h3
   } cmd_t;

   typedef enum logic [2:0] {
      EVA_POSEDGE = 3'h0,
      EVA_ANYEDGE = 3'h1,
      EVA_HIGHLVL = 3'h2,
      EVA_UPDOWN  = 3'h3
   } eva_t;

   typedef enum logic [2:0] {
      EVB_NONE     = 3'h0,
      EVB_UPDOWN   = 3'h3,
      EVB_RST_POS  = 3'h4,
      EVB_RST_ANY  = 3'h5,
      EVB_RST_HIGH = 3'h6
   } evb_t;
endpackage

/* logic/timer_buffer_update_control.sv */
// Timer control: command, lock, direction and buffer valid tracking
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
module timer_buffer_update_control
   import timer_ctl_pkg::*;
(
   input  wire logic        core_clk,      // 100 MHz clock
   input  wire logic        rst,           // Async reset, high
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB enable
   input  wire logic        pwrite,        // APB write
   input  wire logic [11:0] paddr,         // APB byte address
   input  wire logic [31:0] pwdata,        // APB write data
   output logic      [31:0] prdata,        // APB read data
   output logic             pready,        // APB ready
   output logic             pslverr,       // Unmapped access
   input  wire logic        eventA,        // Event input A, async
   input  wire logic        eventB,        // Event input B, async
   output logic      [15:0] count,         // Counter value
   output logic             countDown,     // Direction, 1 = down
   output logic      [15:0] periodActive,  // Active period
   output logic      [15:0] compare0,      // Active compare 0
   output logic      [15:0] compare1,      // Active compare 1
   output logic      [15:0] compare2       // Active compare 2
);

   idx_t        idx;
   logic        wrEdge;
   logic        enable;
   logic        splitMode;
   logic        autoLock;
   logic [2:0]  cmpEn;
   logic [7:0]  event_input_control;
   logic        lockUpd;
   logic [3:0]  bufValid;
   logic [15:0] periodBuf;
   logic [15:0] cmpBuf [NUM_CMP];
   logic [15:0] cmpAct [NUM_CMP];
   logic [1:0]  evSync1;
   logic [1:0]  evSync2;
   logic [1:0]  evPrev;
   logic        cmdUpd;
   logic        cmdRestart;
   logic        cmdHard;
   logic        hardRst;
   logic        wrDlc;
   cmd_t        cmdWord;
   logic        countEn;
   logic        stepA;
   logic        restartB;
   logic        restartNow;
   logic        updateHw;
   logic        doUpdate;
   logic        allValid;
   logic [15:0] next_count;
   logic [3:0]  bvSetV;
   logic [3:0]  bvClrV;
   logic [2:0]  cmpBufWr;
   logic [31:0] readData;
   logic        unmapped;
   logic        aRise, aFall, bRise, bFall;
   eva_t        actA;
   evb_t        actB;

   // True when a write to the given index completes this edge
   function automatic logic wrHit(input logic e, input idx_t a,
                                  input idx_t w);
      return e && (a == w);
   endfunction

   assign idx    = paddr[IDX_W+1:2];
   assign wrEdge = psel && penable && pready && pwrite;
   assign wrDlc  = wrHit(wrEdge, idx, IDX_DLC_SET) ||
                   wrHit(wrEdge, idx, IDX_DLC_CLR);
   assign actA   = eva_t'(event_input_control[EVA_LSB+2:EVA_LSB]);
   assign actB   = evb_t'(event_input_control[EVB_LSB+2:EVB_LSB]);

   // APB slave: one wait-free access phase, answer from flops
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= RST32;
      end else begin
         pready  <= psel && !penable && !pready;
         pslverr <= psel && !penable && unmapped;
         if (psel && !penable && !pwrite) begin
            prdata <= readData;
         end
      end
   end

   // Read mux; both views of a pair show the same state
   always_comb begin
      readData = RST32;
      unmapped = 1'b0;
      unique case (idx)
         IDX_CTRL:    readData[ENABLE_BIT] = enable;
         IDX_CFG: begin
            readData[AUTO_LOCK_UPDATE_BIT] = autoLock;
            readData[CMPEN_LSB+2:CMPEN_LSB] = cmpEn;
         end
         IDX_SPLIT:   readData[SPLIT_BIT] = splitMode;
         IDX_DLC_CLR,
         IDX_DLC_SET: begin
            readData[LOCK_UPDATE_BIT] = lockUpd;
            readData[DIR_BIT]  = countDown;
         end
         IDX_BV_CLR,
         IDX_BV_SET:  readData[BV_MSB:0] = bufValid;
         IDX_EVENT_INPUT_CONTROL:  readData[7:0] = event_input_control;
         IDX_COUNT:   readData[15:0] = count;
         IDX_PERIOD_BUFFER:  readData[15:0] = periodBuf;
         IDX_CMPBUF0: readData[15:0] = cmpBuf[0];
         IDX_CMPBUF0 + IDX_CMP_STEP: readData[15:0] = cmpBuf[1];
         idx_t'(IDX_CMPBUF0 + 2 * IDX_CMP_STEP): readData[15:0] = cmpBuf[2];
         default:     unmapped = 1'b1;
      endcase
   end

   // Plain configuration registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enable    <= 1'b0;
         splitMode <= 1'b0;
         autoLock  <= 1'b0;
         cmpEn     <= 3'h0;
         event_input_control    <= RST8;
      end else begin
         if (wrHit(wrEdge, idx, IDX_CTRL)) begin
            enable <= pwdata[ENABLE_BIT];
         end
         if (wrHit(wrEdge, idx, IDX_SPLIT)) begin
            splitMode <= pwdata[SPLIT_BIT];
         end
         if (wrHit(wrEdge, idx, IDX_CFG)) begin
            autoLock <= pwdata[AUTO_LOCK_UPDATE_BIT];
            cmpEn    <= pwdata[CMPEN_LSB+2:CMPEN_LSB];
         end
         if (wrHit(wrEdge, idx, IDX_EVENT_INPUT_CONTROL)) begin
            event_input_control <= pwdata[7:0];
         end
      end
   end

   // Events come from outside: two flops, then edge history
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         evSync1 <= 2'h0;
         evSync2 <= 2'h0;
         evPrev  <= 2'h0;
      end else begin
         evSync1 <= {eventB, eventA};
         evSync2 <= evSync1;
         evPrev  <= evSync2;
      end
   end

   assign aRise = evSync2[0] && !evPrev[0];
   assign aFall = !evSync2[0] && evPrev[0];
   assign bRise = evSync2[1] && !evPrev[1];
   assign bFall = !evSync2[1] && evPrev[1];

   // Event A qualifies counting; disabled input counts every cycle
   always_comb begin
      stepA = 1'b1;
      if (event_input_control[EVA_EN_BIT]) begin
         unique case (actA)
            EVA_POSEDGE: stepA = aRise;
            EVA_ANYEDGE: stepA = aRise || aFall;
            EVA_HIGHLVL: stepA = evSync2[0];
            EVA_UPDOWN:  stepA = 1'b1;
            default:     stepA = 1'b0;
         endcase
      end
   end

   // Event B restart actions; reserved codes do nothing
   always_comb begin
      restartB = 1'b0;
      if (event_input_control[EVB_EN_BIT]) begin
         unique case (actB)
            EVB_RST_POS:  restartB = bRise;
            EVB_RST_ANY:  restartB = bRise || bFall;
            EVB_RST_HIGH: restartB = evSync2[1];
            default:      restartB = 1'b0;
         endcase
      end
   end

   // Commands are latched at the write and act one cycle later
   assign cmdWord = wrDlc ? cmd_t'(pwdata[CMD_MSB:CMD_LSB]) : CMD_NONE;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cmdUpd     <= 1'b0;
         cmdRestart <= 1'b0;
         cmdHard    <= 1'b0;
      end else begin
         cmdUpd     <= (cmdWord == CMD_UPDATE);
         cmdRestart <= (cmdWord == CMD_RESTART);
         cmdHard    <= (cmdWord == CMD_HARD);
      end
   end

   assign hardRst    = cmdHard && !enable;
   assign restartNow = cmdRestart || restartB;
   assign countEn    = enable && stepA;

   // Split halves both count down and wrap at their period byte
   always_comb begin
      if (splitMode) begin
         next_count[7:0] = (count[7:0] == RST8) ? periodActive[7:0]
                                                : count[7:0] - 8'h01;
         next_count[15:8] = (count[15:8] == RST8) ? periodActive[15:8]
                                                  : count[15:8] - 8'h01;
      end else if (countDown) begin
         next_count = (count == RST16) ? periodActive
                                       : count - 16'h0001;
      end else begin
         next_count = (count == periodActive) ? RST16
                                              : count + 16'h0001;
      end
   end

   // Counter; restart leaves every configuration register alone
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         count <= RST16;
      end else if (hardRst || restartNow) begin
         count <= RST16;
      end else if (countEn) begin
         count <= next_count;
      end
   end

   // Outside split mode, hardware update at top going up, bottom going down
   assign updateHw = countEn && !splitMode &&
                     (countDown ? (count == RST16)
                                : (count == periodActive));
   assign doUpdate = cmdUpd ||
                     (updateHw && !lockUpd);
   assign allValid = &(bufValid[BV_MSB:1] | ~cmpEn);

   // Direction: software views win over event control
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         countDown <= 1'b0;
      end else if (hardRst) begin
         countDown <= 1'b0;
      end else if (wrHit(wrEdge, idx, IDX_DLC_SET) && pwdata[DIR_BIT]) begin
         countDown <= 1'b1;
      end else if (wrHit(wrEdge, idx, IDX_DLC_CLR) && pwdata[DIR_BIT]) begin
         countDown <= 1'b0;
      end else if (countEn && event_input_control[EVB_EN_BIT] && actB == EVB_UPDOWN) begin
         countDown <= evSync2[1];
      end else if (countEn && event_input_control[EVA_EN_BIT] && actA == EVA_UPDOWN) begin
         countDown <= evSync2[0];
      end
   end

   // Lock update, with automatic hold until enabled buffers are valid
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lockUpd <= 1'b0;
      end else if (hardRst) begin
         lockUpd <= 1'b0;
      end else if (wrHit(wrEdge, idx, IDX_DLC_SET) && pwdata[LOCK_UPDATE_BIT]) begin
         lockUpd <= 1'b1;
      end else if (autoLock && doUpdate) begin
         // Relock after an update beats a software clear in the same cycle
         lockUpd <= 1'b1;
      end else if (wrHit(wrEdge, idx, IDX_DLC_CLR) && pwdata[LOCK_UPDATE_BIT]) begin
         lockUpd <= 1'b0;
      end else if (wrHit(wrEdge, idx, IDX_CFG) && pwdata[AUTO_LOCK_UPDATE_BIT] &&
                   !autoLock) begin
         lockUpd <= 1'b1;
      end else if (autoLock && lockUpd && allValid) begin
         lockUpd <= 1'b0;
      end
   end

   // Valid flags: a set in the same cycle beats clear and update
   assign bvSetV = (wrHit(wrEdge, idx, IDX_BV_SET) ? pwdata[BV_MSB:0]
                                                  : 4'h0) |
                   {cmpBufWr, wrHit(wrEdge, idx, IDX_PERIOD_BUFFER)};
   assign bvClrV = wrHit(wrEdge, idx, IDX_BV_CLR) ? pwdata[BV_MSB:0]
                                                 : 4'h0;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bufValid <= 4'h0;
      end else if (hardRst) begin
         bufValid <= 4'h0;
      end else begin
         bufValid <= bvSetV |
                     (bufValid & ~bvClrV & ~{4{doUpdate}});
      end
   end

   // Period buffer and its active copy
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         periodBuf    <= RST16;
         periodActive <= RST16;
      end else if (hardRst) begin
         periodBuf    <= RST16;
         periodActive <= RST16;
      end else begin
         if (wrHit(wrEdge, idx, IDX_PERIOD_BUFFER)) begin
            periodBuf <= pwdata[15:0];
         end
         if (doUpdate) begin
            periodActive <= periodBuf;
         end
      end
   end

   // One buffer and active register per compare channel
   for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
      assign cmpBufWr[i] = wrHit(wrEdge, idx,
                                 IDX_CMPBUF0 + idx_t'(i) * IDX_CMP_STEP);
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            cmpBuf[i] <= RST16;
            cmpAct[i] <= RST16;
         end else if (hardRst) begin
            cmpBuf[i] <= RST16;
            cmpAct[i] <= RST16;
         end else begin
            if (cmpBufWr[i]) begin
               cmpBuf[i] <= pwdata[15:0];
            end
            if (doUpdate) begin
               cmpAct[i] <= cmpBuf[i];
            end
         end
      end
   end

   assign compare0 = cmpAct[0];
   assign compare1 = cmpAct[1];
   assign compare2 = cmpAct[2];

   // Checks on the control behaviour
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_restart_write;
      wrDlc && pwdata[CMD_MSB:CMD_LSB] == CMD_RESTART;
   endsequence

   sequence s_restart_act;
      cmdRestart ##1 (count == RST16);
   endsequence

   property p_cmd_reads_zero;
      (pready && !pwrite && (idx == IDX_DLC_CLR || idx == IDX_DLC_SET))
         |-> prdata[CMD_MSB:CMD_LSB] == 2'b00;
   endproperty
   a_cmd_reads_zero: assert property (p_cmd_reads_zero)
      else $error("command field read back nonzero");

   property p_clear_dir;
      wrHit(wrEdge, idx, IDX_DLC_CLR) && pwdata[DIR_BIT] |=> !countDown;
   endproperty
   a_clear_dir: assert property (p_clear_dir)
      else $error("clear view did not clear direction");

   property p_set_bv;
      wrHit(wrEdge, idx, IDX_BV_SET) && pwdata[0] |=> bufValid[0];
   endproperty
   a_set_bv: assert property (p_set_bv)
      else $error("set view did not set period valid");

   property p_hard_ignored;
      cmdHard && enable && !doUpdate |=> periodActive == $past(periodActive);
   endproperty
   a_hard_ignored: assert property (p_hard_ignored)
      else $error("hard reset acted while enabled");

   property p_lock_blocks;
      updateHw && lockUpd && !cmdUpd
         |=> periodActive == $past(periodActive);
   endproperty
   a_lock_blocks: assert property (p_lock_blocks)
      else $error("locked update transferred period");

   property p_force_update;
      cmdUpd && !hardRst |=> periodActive == $past(periodBuf);
   endproperty
   a_force_update: assert property (p_force_update)
      else $error("forced update did not transfer");

   property p_restart;
      s_restart_write |=> s_restart_act;
   endproperty
   a_restart: assert property (p_restart)
      else $error("restart did not clear counter");

   property p_update_clears;
      doUpdate && !wrEdge |=> bufValid == 4'h0;
   endproperty
   a_update_clears: assert property (p_update_clears)
      else $error("update left a valid flag set");

endmodule

/* test/timer_buffer_update_control_tb_top.sv */
// Self-checking bench for the timer buffer and update control block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin \
   badCount++; $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module timer_buffer_update_control_tb_top
   import timer_ctl_pkg::*;
;
   logic        core_clk;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        eventA;
   logic        eventB;
   logic [15:0] count;
   logic        countDown;
   logic [15:0] periodActive;
   logic [15:0] compare0;
   logic [15:0] compare1;
   logic [15:0] compare2;
   logic [31:0] rd;
   logic        lastErr;
   int          badCount;
   int          nTests;

   timer_buffer_update_control DUT (
      .core_clk    (core_clk),
      .rst         (rst),
      .psel        (psel),
      .penable     (penable),
      .pwrite      (pwrite),
      .paddr       (paddr),
      .pwdata      (pwdata),
      .prdata      (prdata),
      .pready      (pready),
      .pslverr     (pslverr),
      .eventA      (eventA),
      .eventB      (eventB),
      .count       (count),
      .countDown   (countDown),
      .periodActive(periodActive),
      .compare0    (compare0),
      .compare1    (compare1),
      .compare2    (compare2)
   );

   // Free-running 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // One APB transfer; the request stands until pready is seen high
   task automatic apb(input logic wr, input idx_t idx, input logic [31:0] wd);
      @(posedge core_clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      // No assumed latency; only the watchdog ends a wait that never ends
      while (pready !== 1'b1) begin
         @(posedge core_clk);
      end
      rd      = prdata;
      lastErr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Let a few edges land, then sample settled outputs
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // Reset values of every view
   task automatic t_reset();
      idx_t ids [5] = '{IDX_DLC_CLR, IDX_DLC_SET, IDX_BV_CLR, IDX_BV_SET,
                        IDX_EVENT_INPUT_CONTROL};
      foreach (ids[i]) begin
         apb(1'b0, ids[i], 32'h0000_0000);
         `CHK("reset view", 32'h0000_0000, rd)
      end
      `CHK("periodActive", 16'h0000, periodActive)
   endtask

   // Set and clear views of direction and lock
   task automatic t_views();
      apb(1'b1, IDX_DLC_SET, 32'h0000_0003);
      apb(1'b0, IDX_DLC_CLR, 32'h0000_0000);
      `CHK("dlc clr view", 32'h0000_0003, rd)
      settle(1);
      `CHK("countDown", 1'b1, countDown)
      apb(1'b1, IDX_DLC_CLR, 32'h0000_0001);
      apb(1'b0, IDX_DLC_SET, 32'h0000_0000);
      `CHK("dlc set view", 32'h0000_0002, rd)
      settle(1);
      `CHK("countDown", 1'b0, countDown)
   endtask

   // Valid flags and a forced update while locked
   task automatic t_buffers();
      apb(1'b1, IDX_PERIOD_BUFFER, 32'h0000_0008);
      apb(1'b1, IDX_CMPBUF0, 32'h0000_0011);
      apb(1'b1, IDX_CMPBUF0 + IDX_CMP_STEP, 32'h0000_0022);
      apb(1'b1, idx_t'(IDX_CMPBUF0 + 2 * IDX_CMP_STEP), 32'h0000_0033);
      apb(1'b0, IDX_BV_SET, 32'h0000_0000);
      `CHK("valid flags", 32'h0000_000F, rd)
      apb(1'b1, IDX_BV_CLR, 32'h0000_0005);
      apb(1'b0, IDX_BV_CLR, 32'h0000_0000);
      `CHK("valid clr", 32'h0000_000A, rd)
      apb(1'b1, IDX_BV_SET, 32'h0000_0005);
      apb(1'b0, IDX_BV_CLR, 32'h0000_0000);
      `CHK("valid set", 32'h0000_000F, rd)
      apb(1'b1, IDX_DLC_SET, 32'h0000_0006);
      settle(2);
      `CHK("periodActive", 16'h0008, periodActive)
      `CHK("compare0", 16'h0011, compare0)
      `CHK("compare1", 16'h0022, compare1)
      `CHK("compare2", 16'h0033, compare2)
      apb(1'b0, IDX_BV_SET, 32'h0000_0000);
      `CHK("flags after update", 32'h0000_0000, rd)
      apb(1'b0, IDX_DLC_SET, 32'h0000_0000);
      `CHK("cmd readback", 32'h0000_0002, rd)
   endtask

   // Hardware update blocked by lock, then taken once unlocked
   task automatic t_lock();
      apb(1'b1, IDX_PERIOD_BUFFER, 32'h0000_0003);
      apb(1'b1, IDX_CTRL, 32'h0000_0001);
      settle(40);
      `CHK("locked period", 16'h0008, periodActive)
      apb(1'b0, IDX_BV_CLR, 32'h0000_0000);
      `CHK("locked flags", 32'h0000_0001, rd)
      apb(1'b1, IDX_DLC_CLR, 32'h0000_0002);
      for (int i = 0; i < 40 && periodActive !== 16'h0003; i++) settle(1);
      `CHK("unlocked period", 16'h0003, periodActive)
      apb(1'b0, IDX_BV_CLR, 32'h0000_0000);
      `CHK("unlocked flags", 32'h0000_0000, rd)
   endtask

   // Restart mid-count clears the counter but keeps configuration
   task automatic t_restart();
      apb(1'b1, IDX_PERIOD_BUFFER, 32'h0000_1000);
      for (int i = 0; i < 20 && periodActive !== 16'h1000; i++) settle(1);
      settle(100);
      apb(1'b1, IDX_DLC_SET, 32'h0000_0008);
      settle(2);
      `CHK("count restarted", 1'b1, count < 16'h0003)
      apb(1'b0, IDX_CTRL, 32'h0000_0000);
      `CHK("ctrl kept", 32'h0000_0001, rd)
   endtask

   // Event B steers the count direction by its level
   task automatic t_eventB();
      apb(1'b1, IDX_EVENT_INPUT_CONTROL, 32'h0000_0070);
      @(posedge core_clk);
      eventB <= 1'b1;
      settle(8);
      `CHK("dir by event", 1'b1, countDown)
      @(posedge core_clk);
      eventB <= 1'b0;
      settle(8);
      `CHK("dir by event", 1'b0, countDown)
      apb(1'b1, IDX_EVENT_INPUT_CONTROL, 32'h0000_0000);
   endtask

   // Hard reset refused while running, taken while stopped
   task automatic t_hard();
      apb(1'b1, IDX_DLC_SET, 32'h0000_000C);
      settle(2);
      `CHK("hard ignored", 16'h1000, periodActive)
      apb(1'b1, IDX_CTRL, 32'h0000_0000);
      apb(1'b1, IDX_DLC_SET, 32'h0000_000C);
      settle(2);
      `CHK("hard period", 16'h0000, periodActive)
      `CHK("hard compare", 16'h0000, compare0)
      `CHK("hard count", 16'h0000, count)
   endtask

   // Event A codes 0-3 and event B codes 3-6 round-trip; unmapped index is refused
   task automatic t_evcodes();
      logic [7:0] v;
      for (int a = 0; a < 4; a++) begin
         v = {3'(a + 3), 1'b1, 3'(a), 1'b1};
         apb(1'b1, IDX_EVENT_INPUT_CONTROL, {24'h00_0000, v});
         apb(1'b0, IDX_EVENT_INPUT_CONTROL, 32'h0000_0000);
         `CHK("event ctrl", {24'h00_0000, v}, rd)
      end
      apb(1'b1, IDX_EVENT_INPUT_CONTROL, 32'h0000_0000);
      apb(1'b0, 8'h0A, 32'h0000_0000);
      `CHK("unmapped err", 1'b1, lastErr)
      `CHK("unmapped data", 32'h0000_0000, rd)
   endtask

   // Auto lock sets lock until enabled compare buffers are valid
   task automatic t_autolock();
      apb(1'b1, IDX_CFG, 32'h0000_0018);
      apb(1'b0, IDX_DLC_CLR, 32'h0000_0000);
      `CHK("auto lock on", 32'h0000_0002, rd)
      apb(1'b1, IDX_CMPBUF0, 32'h0000_0044);
      apb(1'b0, IDX_DLC_CLR, 32'h0000_0000);
      `CHK("auto lock off", 32'h0000_0000, rd)
   endtask

   // Forced update relocks; split halves count down; event A gates steps
   task automatic t_split();
      apb(1'b1, IDX_PERIOD_BUFFER, 32'h0000_0305);
      apb(1'b1, IDX_DLC_SET, 32'h0000_0004);
      apb(1'b0, IDX_DLC_CLR, 32'h0000_0000);
      `CHK("auto relock", 32'h0000_0002, rd)
      `CHK("split period", 16'h0305, periodActive)
      apb(1'b1, IDX_SPLIT, 32'h0000_0001);
      apb(1'b0, IDX_SPLIT, 32'h0000_0000);
      `CHK("split mode", 32'h0000_0001, rd)
      apb(1'b1, IDX_CTRL, 32'h0000_0001);
      settle(7);
      `CHK("split count", 16'h0105, count)
      apb(1'b1, IDX_EVENT_INPUT_CONTROL, 32'h0000_0001);
      @(posedge core_clk);
      eventA <= 1'b1;
      settle(1);
      `CHK("held by event", 16'h0202, count)
      settle(3);
      `CHK("event step", 16'h0101, count)
   endtask

   // Verdict and end of run
   task automatic results();
      if (badCount == 0 && nTests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0000_0000;
      eventA = 1'b0; eventB = 1'b0;
      badCount = 0; nTests = 0;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_views();
      t_buffers();
      t_lock();
      t_restart();
      t_eventB();
      t_hard();
      t_evcodes();
      t_autolock();
      t_split();
      results();
   end

   // Watchdog well beyond the expected run of under a thousand cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      badCount++;
      results();
   end
endmodule
